// [shared/flash_host_consts.vh]
// Register map, field positions and bus timing for the flash host controller
`ifndef FLASH_HOST_CONSTS_VH
`define FLASH_HOST_CONSTS_VH

// Register indices on the software port
`define REG_CTRL        4'h0
`define REG_ADDR        4'h1
`define REG_WDATA       4'h2
`define REG_CFG         4'h3
`define REG_STATUS      4'h4
`define REG_RDATA       4'h5
`define REG_PAGE0       4'h6
`define REG_PAGE1       4'h7
`define REG_PAGE2       4'h8
`define REG_PAGE3       4'h9

// Control register: operation code, a write starts it
`define OP_LSB          0
`define OP_MSB          2
`define OP_WRITE        3'h1
`define OP_READ         3'h2
`define OP_PAGE         3'h3
`define OP_IDENT        3'h4
`define OP_RESET        3'h5

// Configuration register fields and reset value
`define CFG_CE_CTRL     0
`define CFG_WP_HIGH     1
`define CFG_PDOWN       2
`define CFG_RESET       3'h2

// Status register fields
`define ST_BUSY         0
`define ST_DONE         1
`define ST_TOGGLE1      2
`define ST_TOGGLE2      3
`define ST_POLL         4
`define ST_ERROR        5

// Data bit positions of the device status word and configuration read
`define DQ_POLL         7
`define DQ_TOGGLE1      6
`define DQ_ERROR        5
`define DQ_TOGGLE2      2
`define DQ_PDOWN_EN     10

// Timing in ns and derived cycle counts at the clock rate
`define CLK_NS          20
`define T_RAND_NS       100
`define T_PAGE_NS       35
`define T_WPULSE_NS     50
`define T_RSTLOW_NS     200
`define T_RSTREC_NS     10000
`define T_RAND_CYC      ((`T_RAND_NS + `CLK_NS - 1) / `CLK_NS)
`define T_PAGE_CYC      ((`T_PAGE_NS + `CLK_NS - 1) / `CLK_NS)
`define T_WPULSE_CYC    ((`T_WPULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define T_RSTLOW_CYC    ((`T_RSTLOW_NS + `CLK_NS - 1) / `CLK_NS)
`define T_RSTREC_CYC    ((`T_RSTREC_NS + `CLK_NS - 1) / `CLK_NS)
// Pin to usable data: three flops plus agreement register
`define SYNC_CYC        4

`endif

// [rtl/flash_pin_sync.v]
// Three-flop synchroniser with agreement filter for the data pins
`timescale 1ns/10ps
module flash_pin_sync (
  // Clock and reset
  input  wire        clk,
  input  wire        nrst,
  // Pin side and filtered result
  input  wire [15:0] pin_in,
  output wire [15:0] data_out
);

  genvar g;

  // One chain per bit; the first flop feeds only the second
  generate
    for (g = 0; g < 16; g = g + 1) begin : bit_chain
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg out_q;
      // Change accepted only once stages two and three agree
      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          s1_q  <= 1'b0;
          s2_q  <= 1'b0;
          s3_q  <= 1'b0;
          out_q <= 1'b0;
        end else begin
          s1_q <= pin_in[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            out_q <= s3_q;
          end
        end
      end
      assign data_out[g] = out_q;
    end
  endgenerate

endmodule

// [rtl/flash_host.v]
// Host controller driving a dual-bank page flash over its parallel pins
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`include "flash_host_consts.vh"

// Contract
// - Chip-select-timed writes with strobe held low
// - Host holds reset low minimum pulse time
// - Read needs chip select and gating low
// - Write needs select, strobe low, gating high
// - Poll status inside the busy bank
module flash_host (
  // Clock and reset
  input  wire        CLK,
  input  wire        NRST,
  // Software register port
  input  wire [3:0]  REG_ADDR,
  input  wire [31:0] REG_WDATA,
  input  wire        REG_WR,
  input  wire        REG_RD,
  output reg  [31:0] REG_RDATA,
  // Flash address and data pins
  output reg  [18:0] ADDRESS_BUS,
  output reg  [15:0] DATA_BUS_O,
  input  wire [15:0] DATA_BUS_I,
  output reg         DATA_BUS_OE,
  // Flash control pins, active low
  output reg         CHIP_SEL_N,
  output reg         OUT_GATE_N,
  output reg         WRITE_STROBE_N,
  output reg         RESET_POWERDOWN_N,
  output reg         WRITE_PROTECT_N
);

  // One-hot sequencer states
  localparam [6:0] S_IDLE   = 7'h01;
  localparam [6:0] S_SETUP  = 7'h02;
  localparam [6:0] S_STROBE = 7'h04;
  localparam [6:0] S_HOLD   = 7'h08;
  localparam [6:0] S_WAITRD = 7'h10;
  localparam [6:0] S_RSTLOW = 7'h20;
  localparam [6:0] S_RSTREC = 7'h40;

  // Cycle counts, cut to the counter width on purpose
  localparam [31:0] RAND_W    = `T_RAND_CYC + `SYNC_CYC;
  localparam [31:0] PAGE_W    = `T_PAGE_CYC + `SYNC_CYC;
  localparam [31:0] WP_W      = `T_WPULSE_CYC;
  localparam [31:0] RLOW_W    = `T_RSTLOW_CYC;
  localparam [31:0] RREC_W    = `T_RSTREC_CYC;
  localparam [11:0] CYC_RAND  = RAND_W[11:0];
  localparam [11:0] CYC_PAGE  = PAGE_W[11:0];
  localparam [11:0] CYC_WP    = WP_W[11:0];
  localparam [11:0] CYC_RLOW  = RLOW_W[11:0];
  localparam [11:0] CYC_RREC  = RREC_W[11:0];

  reg  [6:0]  state_q;
  reg  [11:0] cnt_q;
  reg  [2:0]  op_q;
  reg  [1:0]  idx_q;
  reg  [18:0] addr_q;
  reg  [15:0] wdata_q;
  reg  [2:0]  cfg_q;
  reg  [15:0] rdata_q;
  reg  [15:0] page_q [0:3];
  reg         done_q;
  reg         tog1_q;
  reg         tog2_q;
  reg         have_prev_q;
  wire [15:0] sync_data;
  wire        start;
  wire        clr_done;
  wire        finish;
  wire        rd_done;
  integer     i;

  // Data pins pass the three-flop filter before use
  flash_pin_sync u_sync (
    .clk      (CLK),
    .nrst     (NRST),
    .pin_in   (DATA_BUS_I),
    .data_out (sync_data)
  );

  // Read-back mux for the software port
  function [31:0] reg_view;
    input [3:0] a;
    begin
      case (a)
        `REG_CTRL:   reg_view = {29'h0000000, op_q};
        `REG_ADDR:   reg_view = {13'h0000, addr_q};
        `REG_WDATA:  reg_view = {16'h0000, wdata_q};
        `REG_CFG:    reg_view = {29'h0000000, cfg_q};
        `REG_STATUS: reg_view = {26'h0000000, rdata_q[`DQ_ERROR], rdata_q[`DQ_POLL],
                                 tog2_q, tog1_q, done_q, (state_q != S_IDLE)};
        `REG_RDATA:  reg_view = {16'h0000, rdata_q};
        `REG_PAGE0:  reg_view = {16'h0000, page_q[0]};
        `REG_PAGE1:  reg_view = {16'h0000, page_q[1]};
        `REG_PAGE2:  reg_view = {16'h0000, page_q[2]};
        `REG_PAGE3:  reg_view = {16'h0000, page_q[3]};
        default:     reg_view = 32'h00000000;
      endcase
    end
  endfunction

  // Start only from idle; a start while busy is ignored
  assign start    = REG_WR && (REG_ADDR == `REG_CTRL) && (state_q == S_IDLE) &&
                    (REG_WDATA[`OP_MSB:`OP_LSB] != 3'h0);
  assign clr_done = REG_WR && (REG_ADDR == `REG_STATUS) && REG_WDATA[`ST_DONE];
  assign rd_done  = (state_q == S_WAITRD) && (cnt_q == 12'h000) &&
                    ((op_q != `OP_PAGE) || (idx_q == 2'h3));
  assign finish   = rd_done || ((state_q == S_HOLD) && (op_q == `OP_WRITE) &&
                    (cnt_q == 12'h000)) ||
                    ((state_q == S_RSTREC) && (cnt_q == 12'h000));

  // Software registers and read data one cycle after the strobe
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      addr_q    <= 19'h00000;
      wdata_q   <= 16'h0000;
      cfg_q     <= `CFG_RESET;
      REG_RDATA <= 32'h00000000;
      done_q    <= 1'b0;
    end else begin
      if (REG_WR && (REG_ADDR == `REG_ADDR)) begin
        addr_q <= REG_WDATA[18:0];
      end
      if (REG_WR && (REG_ADDR == `REG_WDATA)) begin
        wdata_q <= REG_WDATA[15:0];
      end
      if (REG_WR && (REG_ADDR == `REG_CFG)) begin
        cfg_q <= REG_WDATA[2:0];
      end
      // Completion wins over a clear in the same cycle
      if (finish) begin
        done_q <= 1'b1;
      end else if (clr_done) begin
        done_q <= 1'b0;
      end
      REG_RDATA <= REG_RD ? reg_view(REG_ADDR) : 32'h00000000;
    end
  end

  // Pin sequencer: every pin is a flop so no strobe can glitch
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_q           <= S_IDLE;
      cnt_q             <= 12'h000;
      op_q              <= 3'h0;
      idx_q             <= 2'h0;
      ADDRESS_BUS       <= 19'h00000;
      DATA_BUS_O        <= 16'h0000;
      DATA_BUS_OE       <= 1'b0;
      CHIP_SEL_N        <= 1'b1;   // Deselected: device in standby
      OUT_GATE_N        <= 1'b1;
      WRITE_STROBE_N    <= 1'b1;
      RESET_POWERDOWN_N <= 1'b1;
      WRITE_PROTECT_N   <= 1'b0;   // Locked blocks guarded in reset and while CFG_WP_HIGH is clear
    end else begin
      WRITE_PROTECT_N <= cfg_q[`CFG_WP_HIGH];
      case (state_q)
        S_IDLE: begin
          cnt_q <= 12'h000;
          idx_q <= 2'h0;
          // Held low here only for an enabled power-down hold
          RESET_POWERDOWN_N <= ~cfg_q[`CFG_PDOWN];
          if (start) begin
            op_q <= REG_WDATA[`OP_MSB:`OP_LSB];
            ADDRESS_BUS <= addr_q;
            case (REG_WDATA[`OP_MSB:`OP_LSB])
              `OP_WRITE: begin
                // Gating stays high across the write
                OUT_GATE_N  <= 1'b1;
                DATA_BUS_O  <= wdata_q;
                DATA_BUS_OE <= 1'b1;
                state_q     <= S_SETUP;
              end
              `OP_READ, `OP_IDENT: begin
                // Special reads are plain random cycles
                if (REG_WDATA[`OP_MSB:`OP_LSB] == `OP_IDENT) begin
                  ADDRESS_BUS <= {addr_q[18:8], 6'h00, addr_q[1:0]};
                end
                state_q <= S_SETUP;
              end
              `OP_PAGE: begin
                // Page starts at word zero of the four-word line
                ADDRESS_BUS <= {addr_q[18:2], 2'h0};
                state_q     <= S_SETUP;
              end
              `OP_RESET: begin
                RESET_POWERDOWN_N <= 1'b0;
                cnt_q             <= CYC_RLOW - 12'h001;
                state_q           <= S_RSTLOW;
              end
              default: begin
                state_q <= S_IDLE;
              end
            endcase
          end
        end
        S_SETUP: begin
          // Address settles one cycle before any strobe falls
          if (op_q == `OP_WRITE) begin
            // Strobe first, select times the cycle
            if (cfg_q[`CFG_CE_CTRL]) begin
              WRITE_STROBE_N <= 1'b0;
              state_q        <= S_HOLD;
              cnt_q          <= 12'h001;
            end else begin
              // Both fall together; address latched at that edge
              CHIP_SEL_N     <= 1'b0;
              WRITE_STROBE_N <= 1'b0;
              cnt_q          <= CYC_WP - 12'h001;
              state_q        <= S_STROBE;
            end
          end else begin
            // Both select and gating low to read
            CHIP_SEL_N <= 1'b0;
            OUT_GATE_N <= 1'b0;
            cnt_q      <= CYC_RAND - 12'h001;
            state_q    <= S_WAITRD;
          end
        end
        S_STROBE: begin
          // Pulse lasts whole cycles, far wider than a noise pulse
          if (cnt_q != 12'h000) begin
            cnt_q <= cnt_q - 12'h001;
          end else begin
            // First rising edge latches data; data held one cycle more
            CHIP_SEL_N <= 1'b1;
            if (!cfg_q[`CFG_CE_CTRL]) begin
              WRITE_STROBE_N <= 1'b1;
            end
            cnt_q   <= 12'h000;
            state_q <= S_HOLD;
          end
        end
        S_HOLD: begin
          // Select-timed write: strobe low one cycle, then select pulse
          if (cnt_q != 12'h000) begin
            CHIP_SEL_N <= 1'b0;
            cnt_q      <= CYC_WP - 12'h001;
            state_q    <= S_STROBE;
          end else begin
            WRITE_STROBE_N <= 1'b1;
            DATA_BUS_OE    <= 1'b0;
            state_q        <= S_IDLE;
          end
        end
        S_WAITRD: begin
          // Sampled after access plus sync delay; long holds stay driven
          if (cnt_q != 12'h000) begin
            cnt_q <= cnt_q - 12'h001;
          end else if ((op_q == `OP_PAGE) && (idx_q != 2'h3)) begin
            // Next word of the page needs only the short access
            idx_q            <= idx_q + 2'h1;
            ADDRESS_BUS[1:0] <= idx_q + 2'h1;
            cnt_q            <= CYC_PAGE - 12'h001;
          end else begin
            // Deselecting lets the device float its outputs
            CHIP_SEL_N <= 1'b1;
            OUT_GATE_N <= 1'b1;
            state_q    <= S_IDLE;
          end
        end
        S_RSTLOW: begin
          // Low for at least the minimum pulse
          if (cnt_q != 12'h000) begin
            cnt_q <= cnt_q - 12'h001;
          end else begin
            RESET_POWERDOWN_N <= 1'b1;
            cnt_q             <= CYC_RREC - 12'h001;
            state_q           <= S_RSTREC;
          end
        end
        S_RSTREC: begin
          // Wait the worst-case recovery; device back in array read
          if (cnt_q != 12'h000) begin
            cnt_q <= cnt_q - 12'h001;
          end else begin
            state_q <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // Captured read words; page slots fill in address order
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rdata_q <= 16'h0000;
      for (i = 0; i < 4; i = i + 1) begin
        page_q[i] <= 16'h0000;
      end
    end else if ((state_q == S_WAITRD) && (cnt_q == 12'h000)) begin
      rdata_q       <= sync_data;
      page_q[idx_q] <= sync_data;
    end
  end

  // Toggle detection across two successive status reads of one bank
  // Software must keep the address inside the busy bank; reads elsewhere
  // are allowed meanwhile but then confuse this comparison
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      tog1_q      <= 1'b0;
      tog2_q      <= 1'b0;
      have_prev_q <= 1'b0;
    end else if (rd_done && (op_q == `OP_READ)) begin
      have_prev_q <= 1'b1;
      tog1_q      <= have_prev_q && (sync_data[`DQ_TOGGLE1] != rdata_q[`DQ_TOGGLE1]);
      tog2_q      <= have_prev_q && (sync_data[`DQ_TOGGLE2] != rdata_q[`DQ_TOGGLE2]);
    end else if ((state_q == S_RSTREC) ||
                 (start && (REG_WDATA[`OP_MSB:`OP_LSB] == `OP_WRITE))) begin
      // A new write or a reset restarts the comparison
      have_prev_q <= 1'b0;
    end
  end

endmodule

// [sim/flash_host_sva.sv]
// Checker for the flash pin protocol of the host controller
`timescale 1ns/10ps
module flash_host_sva (
  // Clock and reset
  input wire        CLK,
  input wire        NRST,
  // Flash pins driven by the host
  input wire [18:0] ADDRESS_BUS,
  input wire [15:0] DATA_BUS_O,
  input wire        DATA_BUS_OE,
  input wire        CHIP_SEL_N,
  input wire        OUT_GATE_N,
  input wire        WRITE_STROBE_N,
  input wire        RESET_POWERDOWN_N
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  // Write window, both strobes low
  wire wlo = !CHIP_SEL_N && !WRITE_STROBE_N;
  a_write_gate_high: assert property (wlo |-> OUT_GATE_N && DATA_BUS_OE)
    else $error("gate low or bus idle in write");
  a_write_pulse_len: assert property ($rose(wlo) |-> wlo[*3] ##1 !wlo)
    else $error("write pulse not three cycles");
  a_addr_held: assert property ($rose(wlo) |-> $stable(ADDRESS_BUS))
    else $error("address moved at write start");
  a_data_held: assert property ($fell(wlo) |-> $stable(DATA_BUS_O) && DATA_BUS_OE)
    else $error("data moved at write end");
  a_gate_with_sel: assert property (!OUT_GATE_N |-> !CHIP_SEL_N && !DATA_BUS_OE)
    else $error("gating without select or bus driven");
  a_read_len: assert property ($fell(OUT_GATE_N) |-> (!OUT_GATE_N && WRITE_STROBE_N)[*8])
    else $error("read access cut short");
  a_rst_pulse_min: assert property ($fell(RESET_POWERDOWN_N) |->
    (!RESET_POWERDOWN_N)[*8] ##1 (!RESET_POWERDOWN_N)[*2])
    else $error("reset pulse too short");
  a_reset_quiet: assert property (!RESET_POWERDOWN_N |-> CHIP_SEL_N)
    else $error("access while reset low");
endmodule

// [sim/flash_dev_model.sv]
// Behavioural dual-bank page flash seen from the host pins
`timescale 1ns/10ps
module flash_dev_model #(
  parameter ACC_NS  = 90,
  parameter PAGE_NS = 30,
  parameter BUSY_NS = 8000,
  parameter MAKER   = 16'h0055, // Arbitrary value
  parameter PART    = 16'h00C6  // Arbitrary value
) (
  // Host side pins
  input  wire [18:0] addr,
  input  wire [15:0] din,
  input  wire        ce_n,
  input  wire        oe_n,
  input  wire        we_n,
  input  wire        rp_n,
  input  wire        wp_n,
  // Data towards the host
  output wire [15:0] dq
);
  logic [15:0] mw [int];
  logic [15:0] rd = 0, last = 0, wd = 0;
  logic [18:0] wa = 0, pa = 0;
  logic        ident = 0, cfg = 0, busy = 0, wr_on = 0, tg = 0, ok = 0, oe_p = 1, hit;
  realtime     tf = 0;
  int          seq = 0;
  // Status inside the busy bank, else special or array data
  function automatic [15:0] rdv(input [18:0] a);
    if (busy && a[18] == wa[18]) begin
      tg = ~tg;
      return {8'h00, ~wd[7], tg, 3'b000, tg, 2'b00};
    end
    if (ident) begin
      if (a[7:2] != 0) return 16'hDEAD;
      case (a[1:0])
        2'b00: return MAKER;
        2'b01: return PART;
        2'b10: return {14'h0, a[18:12] == 7'h7F, 1'b1};
        default: return {5'h0, cfg, 10'h0};
      endcase
    end
    return mw.exists(a) ? mw[a] : a[15:0] ^ 16'h5A5A;
  endfunction
  // Address on the later falling strobe, gating high
  always @(negedge ce_n or negedge we_n) begin
    if (!ce_n && !we_n && oe_n && rp_n) begin
      wa = addr;
      wr_on = 1;
      tf = $realtime;
    end
  end
  // Data on the first rising strobe; narrow pulses dropped
  always @(posedge ce_n or posedge we_n) begin
    if (wr_on && $realtime - tf >= 5) begin
      wd = din;
      if (wd == 16'h0090) ident = 1;
      else if (wd == 16'h00F0) ident = 0;
      else if (wd == 16'h0060) cfg = wa[10];
      else if (wp_n || wa[18:12] != 7'h7F) begin
        mw[wa] = wd;
        busy = 1;
        busy <= #BUSY_NS 0;
      end
    end
    wr_on = 0;
  end
  // Reset aborts work and returns to array read, config kept
  always @(negedge rp_n) begin
    busy = 0;
    ident = 0;
    wr_on = 0;
  end
  // Page hit is fast; data is wrong until access time ends
  always @(addr or ce_n or oe_n or rp_n) begin
    last = dq;
    seq = seq + 1;
    hit = !oe_p && addr[18:2] == pa[18:2] && !ident;
    oe_p = oe_n | ce_n;
    pa = addr;
    ok = 0;
    fork
      automatic int s = seq;
      begin
        #(hit ? PAGE_NS : ACC_NS);
        if (s == seq && !ce_n && !oe_n) begin // Only selected reads advance toggles
          rd = rdv(addr);
          ok = 1;
        end
      end
    join_none
  end
  // Read data only when selected, gated and out of reset, else the inverted last word
  assign dq = (!ce_n && !oe_n && rp_n) ? (ok ? rd : ~rd) : ~last;
endmodule

// [sim/tb.sv]
// Self-checking bench for the flash host controller
`timescale 1ns/10ps
`include "flash_host_consts.vh"
module tb;
  logic        CLK = 0, NRST = 0, REG_WR = 0, REG_RD = 0, rd_d = 0;
  logic [3:0]  REG_ADDR = 0;
  logic [31:0] REG_WDATA = 0, v = 0;
  logic [31:0] eq[$], mq[$];
  logic [15:0] x = 16'd4645;
  logic [18:0] pg;
  wire  [31:0] REG_RDATA;
  wire  [18:0] ADDRESS_BUS;
  wire  [15:0] DATA_BUS_O, DATA_BUS_I, dev_q;
  wire         DATA_BUS_OE, CHIP_SEL_N, OUT_GATE_N, WRITE_STROBE_N;
  wire         RESET_POWERDOWN_N, WRITE_PROTECT_N;
  int          num_errors = 0, cmp_count = 0, i;
  // Shared data wire
  assign DATA_BUS_I = DATA_BUS_OE ? DATA_BUS_O : dev_q;
  flash_host dut (.CLK(CLK), .NRST(NRST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .ADDRESS_BUS(ADDRESS_BUS),
    .DATA_BUS_O(DATA_BUS_O), .DATA_BUS_I(DATA_BUS_I), .DATA_BUS_OE(DATA_BUS_OE),
    .CHIP_SEL_N(CHIP_SEL_N), .OUT_GATE_N(OUT_GATE_N), .WRITE_STROBE_N(WRITE_STROBE_N),
    .RESET_POWERDOWN_N(RESET_POWERDOWN_N), .WRITE_PROTECT_N(WRITE_PROTECT_N));
  flash_dev_model #(.ACC_NS(95)) dev (.addr(ADDRESS_BUS), .din(DATA_BUS_O),
    .ce_n(CHIP_SEL_N), .oe_n(OUT_GATE_N), .we_n(WRITE_STROBE_N),
    .rp_n(RESET_POWERDOWN_N), .wp_n(WRITE_PROTECT_N), .dq(dev_q));
  initial forever #10 CLK = ~CLK;
  function automatic [15:0] nx(input [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic report_and_stop;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input [3:0] r, input [31:0] w);
    @(posedge CLK);
    REG_ADDR <= r;
    REG_WDATA <= w;
    REG_WR <= 1;
    @(posedge CLK);
    REG_WR <= 0;
  endtask
  // A zero mask only fetches the word
  task automatic rd(input [3:0] r, input [31:0] e, input [31:0] m);
    eq.push_back(e);
    mq.push_back(m);
    @(posedge CLK);
    REG_ADDR <= r;
    REG_RD <= 1;
    @(posedge CLK);
    REG_RD <= 0;
    #1 v = REG_RDATA;
  endtask
  task automatic op(input [2:0] c);
    wr(`REG_CTRL, {29'h0, c});
    v = 0;
    for (int k = 0; k < 1000 && v[1] !== 1'b1; k++) rd(`REG_STATUS, 0, 0);
    if (v[1] !== 1'b1) begin
      num_errors++;
      report_and_stop;
    end
    wr(`REG_STATUS, 32'h2);
  endtask
  task automatic cmd(input [18:0] ad, input [15:0] c);
    wr(`REG_WDATA, {16'h0, c});
    wr(`REG_ADDR, {13'h0, ad});
    op(`OP_WRITE);
  endtask
  task automatic rda(input [18:0] ad, input [15:0] e);
    wr(`REG_ADDR, {13'h0, ad});
    op(`OP_READ);
    rd(`REG_RDATA, {16'h0, e}, '1);
  endtask
  task automatic idr(input [18:0] ad, input [31:0] e, input [31:0] m);
    wr(`REG_ADDR, {13'h0, ad});
    op(`OP_IDENT);
    rd(`REG_RDATA, e, m);
  endtask
  // Program, optionally probe both banks while busy, poll to the end
  task automatic prog(input [18:0] ad, input [15:0] dv, input [15:0] e, input bit dual);
    cmd(ad, dv);
    if (dual) begin
      rda(19'h00123, 16'h0123 ^ 16'h5A5A);
      wr(`REG_ADDR, {13'h0, ad});
      op(`OP_READ);
      op(`OP_READ);
      rd(`REG_STATUS, {26'h0, 1'b0, ~dv[7], 4'b1100}, 32'h3C);
    end
    for (int k = 0; k < 50 && v[15:0] !== e; k++) begin
      op(`OP_READ);
      rd(`REG_RDATA, 0, 0);
    end
    rd(`REG_RDATA, {16'h0, e}, '1);
  endtask
  // Compare each read answer that has a nonzero mask with the oldest note
  always @(posedge CLK) begin
    if (rd_d) begin
      if (mq[0] != 0) begin
        cmp_count++;
        if ((REG_RDATA & mq[0]) !== (eq[0] & mq[0])) begin
          num_errors++;
          $display("[FAIL] %0t got %h exp %h", $time, REG_RDATA, eq[0]);
        end
      end
      void'(eq.pop_front());
      void'(mq.pop_front());
    end
    rd_d <= REG_RD;
  end
  // Hang guard, well past the expected run length
  initial begin
    #1000000;
    num_errors++;
    report_and_stop;
  end
  initial begin
    repeat (16) @(posedge CLK);
    NRST <= 1;
    rd(`REG_CFG, 32'h2, '1);
    rd(`REG_STATUS, 0, '1);
    rd(4'hF, 0, '1);
    // Page reads then a random read in the same page
    for (i = 0; i < 4; i++) begin
      x = nx(x);
      pg = {x[2:0], x[15:2], 2'b00};
      wr(`REG_ADDR, {13'h0, pg});
      op(`OP_PAGE);
      for (int k = 0; k < 4; k++) rd(`REG_PAGE0 + 4'(k), pg[15:0] ^ 16'h5A5A ^ k, '1);
      rda(pg | 19'h3, (pg[15:0] | 16'h3) ^ 16'h5A5A);
    end
    x = nx(x);
    prog({3'b100, x}, x | 16'h8000, x | 16'h8000, 1);
    wr(`REG_CFG, 32'h3);
    x = nx(x);
    prog({3'b000, x}, x | 16'h8000, x | 16'h8000, 0);
    wr(`REG_CFG, 32'h0);
    prog(19'h7F055, 16'h8421, 16'hF055 ^ 16'h5A5A, 0);
    wr(`REG_CFG, 32'h2);
    // Special reads with address bits 7..2 set by software
    cmd(19'h00555, 16'h0090);
    idr(19'h000FC, 32'h55, '1);
    idr(19'h000FD, 32'hC6, '1);
    idr(19'h7F0FE, 32'h3, '1);
    idr(19'h100FE, 32'h1, '1);
    idr(19'h000FF, 0, 32'h400);
    cmd(19'h00400, 16'h0060);
    idr(19'h000FF, 32'h400, 32'h400);
    op(`OP_RESET);
    rda(19'h00003, 16'h0003 ^ 16'h5A5A);
    cmd(19'h00555, 16'h0090);
    idr(19'h000FF, 32'h400, 32'h400);
    cmd(19'h00555, 16'h00F0);
    // Power-down hold, then normal reads again
    wr(`REG_CFG, 32'h6);
    for (i = 0; i < 6; i++) rd(`REG_CFG, 32'h6, '1);
    wr(`REG_CFG, 32'h2);
    rda(19'h00007, 16'h0007 ^ 16'h5A5A);
    report_and_stop;
  end
endmodule
bind flash_host flash_host_sva chk (.CLK(CLK), .NRST(NRST), .ADDRESS_BUS(ADDRESS_BUS),
  .DATA_BUS_O(DATA_BUS_O), .DATA_BUS_OE(DATA_BUS_OE), .CHIP_SEL_N(CHIP_SEL_N),
  .OUT_GATE_N(OUT_GATE_N), .WRITE_STROBE_N(WRITE_STROBE_N),
  .RESET_POWERDOWN_N(RESET_POWERDOWN_N));
